// ### hdl/rsc_params.svh
// Purpose: constants for the reset source and calibration block
// Assumes: byte addresses on a 32-bit APB, 125 MHz pclk
// Notes: definitions only
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_OFF_FACTORY_CALIBRATION_WORD 14'h2008
`define RSC_OFF_CAUSE 14'h0000
`define RSC_OFF_CTRL 14'h0004
`define RSC_OFF_SCRATCH 14'h000C
`define RSC_OFF_IRQ_STAT 14'h0010
`define RSC_OFF_IRQ_MASK 14'h0014
`define RSC_CAL_OSC_LSB 6
`define RSC_CAL_OSC_MSB 12
`define RSC_CAL_POR_LSB 3
`define RSC_CAL_POR_MSB 4
`define RSC_CAL_BOD_LSB 0
`define RSC_CAL_BOD_MSB 2
`define RSC_CAL_MASK 14'h1FDF
`define RSC_CAL_RESET 14'h0001
`define RSC_CTRL_RESET 32'h0000_0001
`define RSC_IRQ_MASK_RESET 8'h00
`define RSC_FILT_NS 200
`define RSC_FILT_CYC ((`RSC_FILT_NS + 7) / 8)
`define RSC_POR_REARM_NS 100000
`define RSC_POR_REARM_CYC ((`RSC_POR_REARM_NS + 7) / 8)
`endif

// ### hdl/rsc_pin_filter.sv
// Purpose: glitch filter for the external reset pin
// Assumes: pin already synchronous to pclk
// Notes: output changes only after the input is stable for LEN cycles
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_filter #(
	parameter int LEN = 25
) (
	// Clocking
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Pin in, filtered out
	input wire logic pin_n,
	output logic filt_n
);
	logic [15:0] cnt_ff;
	logic filt_ff;

	// Count stable cycles; any change of the raw level restarts the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 16'h0000;
			filt_ff <= 1'b1;
		end else if (clk_en) begin
			if (pin_n == filt_ff) begin
				cnt_ff <= 16'h0000;
			end else if (cnt_ff >= 16'(LEN - 1)) begin
				cnt_ff <= 16'h0000;
				filt_ff <= pin_n;
			end else begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end
	assign filt_n = filt_ff;

	property p_short_ignored;
		@(posedge pclk) disable iff (!presetn)
		(pin_n != filt_ff && cnt_ff < 16'(LEN - 1)) |=> $stable(filt_ff);
	endproperty
	a_short_ignored: assert property (p_short_ignored) else $error("filter followed glitch");
endmodule // rsc_pin_filter
`default_nettype wire

// ### hdl/rsc_pkg.sv
// Purpose: types for the reset source and calibration block
// Assumes: nothing
// Notes: constants live in rsc_params.svh
`default_nettype none
package rsc_pkg;
	typedef enum logic [2:0] {
		RSC_CAUSE_NONE, RSC_CAUSE_POR, RSC_CAUSE_WDT_RUN, RSC_CAUSE_WDT_SLEEP,
		RSC_CAUSE_PIN_RUN, RSC_CAUSE_PIN_SLEEP, RSC_CAUSE_BOD
	} rsc_cause_e;
	typedef struct packed {
		logic por_n;
		logic bod_n;
		logic expiry_n;
		logic sleep_n;
	} rsc_flags_s;
	typedef struct packed {
		logic supply_ok;
		logic supply_at_gnd;
		logic brownout_low;
		logic brownout_detect_en;
	} rsc_supply_s;
endpackage
`default_nettype wire

// ### hdl/rsc_reset_ctrl.sv
// Purpose: reset source detection, reset hold and calibration word access
// Assumes: supply monitor inputs and pin synchronous to pclk; APB slave, zero wait
// Notes: interrupt on each new reset cause, cleared by reading the status
//
// Contract
// - Oscillator trim in calibration bits 12:6, signed, zero is centre
// - Power-on trim in bits 4:3, 00 lowest, 11 highest threshold
// - Brown-out trim in bits 2:0, 000 reserved, 001 lowest, 111 highest
// - Six reset causes are told apart
// - Unaffected registers unknown on power-on, kept on other resets
// - Other registers take reset values on power-on, pin, watchdog, brown-out; here stat_ff and mask_ff reset only on presetn
// - Watchdog wake-up from sleep is not a reset
// - Expiry and sleep flags patterned by cause for software
// - Flag encodings per cause as listed for each reset kind
// - External reset pin filtered against short glitches
// - Watchdog reset never drives the external pin low
// - Power-on detector holds reset until supply is good
// - With brown-out detect, reset held until supply above threshold
// - No reset on falling supply; rearm after 100 us at ground
// - Pin enable clear ties pin inactive and enables a weak pull-up
// - Programming entry via pin works even with pin tied; here it is taken from the prog_entry input, not the pin
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module rsc_reset_ctrl import rsc_pkg::*; #(
	parameter int FILT_CYC = `RSC_FILT_CYC,
	parameter int REARM_CYC = `RSC_POR_REARM_CYC,
	parameter logic [13:0] CAL_INIT = `RSC_CAL_RESET
) (
	// Clocking
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Supply monitors and events
	input wire rsc_supply_s supply,
	input wire logic wdt_expire,
	input wire logic wdt_asleep,
	input wire logic wdt_wake,
	input wire logic sleep_enter,
	// External reset pin (open drain, never driven low here)
	input wire logic ext_pin_in,
	output logic ext_pin_out,
	output logic ext_pin_oe,
	output logic ext_pin_pullup,
	input wire logic ext_pin_enable,
	input wire logic prog_entry,
	// Reset, programming mode and interrupt outputs
	output logic core_rst_n,
	output logic core_soft_rst_n,
	output logic prog_mode,
	output logic irq
);
	logic pin_filt_n;
	logic pin_gated_n;
	logic [31:0] rearm_cnt_ff;
	logic por_armed_ff;
	logic por_hold_ff;
	logic bod_hold_ff;
	logic pin_hold_ff;
	logic wdt_hold_ff;
	logic rst_req;
	logic sync1_ff;
	logic sync2_ff;
	logic soft1_ff;
	logic soft2_ff;
	rsc_cause_e cause_ff;
	rsc_cause_e nxt_cause;
	rsc_flags_s flags_ff;
	logic asleep_ff;
	logic [13:0] cal_ff;
	logic [31:0] scratch_ff;
	logic [31:0] ctrl_ff;
	logic [7:0] stat_ff;
	logic [7:0] mask_ff;
	logic [31:0] prdata_ff;
	logic irq_ff;
	logic prog_ff;
	logic pullup_ff;
	logic wr;
	logic rd;
	logic [7:0] ev;

	// Mask out unimplemented calibration bits
	function automatic logic [31:0] cal_read(input logic [13:0] c);
		cal_read = {18'h00000, c & `RSC_CAL_MASK};
	endfunction

	assign wr = psel && penable && pwrite && clk_en;
	assign rd = psel && penable && !pwrite && clk_en;

	// Pin is tied inactive when disabled; programming entry comes from prog_entry, not the pin
	assign pin_gated_n = ext_pin_enable ? pin_filt_n : 1'b1;

	rsc_pin_filter #(.LEN(FILT_CYC)) u_filt (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin_n(ext_pin_in),
		.filt_n(pin_filt_n)
	);

	// Programming entry taken from the prog_entry input, not the pin, whatever the tie option
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_ff <= 1'b0;
			pullup_ff <= 1'b0;
		end else if (clk_en) begin
			prog_ff <= prog_entry;
			pullup_ff <= !ext_pin_enable;
		end
	end

	// Power-on detector: rearm only after the supply sat at ground long enough
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rearm_cnt_ff <= 32'h0000_0000;
			por_armed_ff <= 1'b1;
			por_hold_ff <= 1'b1;
		end else if (clk_en) begin
			if (supply.supply_at_gnd) begin
				if (rearm_cnt_ff >= 32'(REARM_CYC - 1)) begin
					por_armed_ff <= 1'b1;
				end else begin
					rearm_cnt_ff <= rearm_cnt_ff + 32'h0000_0001;
				end
			end else begin
				rearm_cnt_ff <= 32'h0000_0000;
			end
			// A falling supply alone never asserts this hold
			if (por_armed_ff && !supply.supply_ok) begin
				por_hold_ff <= 1'b1;
			end else if (supply.supply_ok) begin
				por_hold_ff <= 1'b0;
				if (por_hold_ff) begin
					por_armed_ff <= 1'b0;
				end
			end
		end
	end

	// Brown-out, pin and watchdog holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bod_hold_ff <= 1'b0;
			pin_hold_ff <= 1'b0;
			wdt_hold_ff <= 1'b0;
		end else if (clk_en) begin
			bod_hold_ff <= supply.brownout_detect_en && supply.brownout_low;
			pin_hold_ff <= !pin_gated_n;
			wdt_hold_ff <= wdt_expire && !wdt_asleep;
		end
	end

	assign rst_req = por_hold_ff || bod_hold_ff || pin_hold_ff || wdt_hold_ff;

	// Assert on the next pclk edge, release through two flops on pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			soft1_ff <= 1'b0;
			soft2_ff <= 1'b0;
		end else if (clk_en) begin
			sync1_ff <= !rst_req;
			sync2_ff <= sync1_ff && !rst_req;
			soft1_ff <= !(rst_req && !por_hold_ff);
			soft2_ff <= soft1_ff && !(rst_req && !por_hold_ff);
		end
	end

	// Cause priority: power-on, brown-out, pin, watchdog
	always_comb begin
		nxt_cause = RSC_CAUSE_NONE;
		if (por_hold_ff) begin
			nxt_cause = RSC_CAUSE_POR;
		end else if (bod_hold_ff) begin
			nxt_cause = RSC_CAUSE_BOD;
		end else if (pin_hold_ff) begin
			nxt_cause = asleep_ff ? RSC_CAUSE_PIN_SLEEP : RSC_CAUSE_PIN_RUN;
		end else if (wdt_hold_ff) begin
			nxt_cause = RSC_CAUSE_WDT_RUN;
		end else if (wdt_expire && wdt_asleep) begin
			nxt_cause = RSC_CAUSE_WDT_SLEEP;
		end
	end

	// Cause and flags; watchdog wake records its cause and flags without a reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_ff <= RSC_CAUSE_NONE;
			flags_ff <= '{por_n: 1'b0, bod_n: 1'b1, expiry_n: 1'b1, sleep_n: 1'b1};
			asleep_ff <= 1'b0;
		end else if (clk_en) begin
			if (sleep_enter) begin
				asleep_ff <= 1'b1;
				flags_ff.sleep_n <= 1'b0;
			end
			if (nxt_cause != RSC_CAUSE_NONE) begin
				cause_ff <= nxt_cause;
			end
			// Sleep must outlive a whole pin reset; cleared on wake or on release
			if (nxt_cause == RSC_CAUSE_WDT_SLEEP || (!rst_req && !sync2_ff)) begin
				asleep_ff <= 1'b0;
			end
			if (wr && paddr == `RSC_OFF_CAUSE && pwdata[3]) begin
				flags_ff.por_n <= 1'b1;
			end
			if (wr && paddr == `RSC_OFF_CAUSE && pwdata[2]) begin
				flags_ff.bod_n <= 1'b1;
			end
			case (nxt_cause)
				RSC_CAUSE_POR: flags_ff <= '{1'b0, flags_ff.bod_n, 1'b1, 1'b1};
				RSC_CAUSE_BOD: flags_ff <= '{1'b1, 1'b0, 1'b1, 1'b1};
				RSC_CAUSE_WDT_RUN: flags_ff.expiry_n <= 1'b0;
				RSC_CAUSE_WDT_SLEEP: begin
					flags_ff.expiry_n <= 1'b0;
					flags_ff.sleep_n <= 1'b0;
				end
				RSC_CAUSE_PIN_SLEEP: begin
					flags_ff.expiry_n <= 1'b1;
					flags_ff.sleep_n <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Scratch survives every reset but power-on
	always_ff @(posedge pclk) begin
		if (clk_en) begin
			if (wr && paddr == `RSC_OFF_SCRATCH) begin
				scratch_ff <= pwdata;
			end
		end
	end

	// Control and calibration take their reset values on any system reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `RSC_CTRL_RESET;
			cal_ff <= `RSC_CAL_RESET;
		end else if (clk_en) begin
			if (!sync2_ff) begin
				ctrl_ff <= `RSC_CTRL_RESET;
			end else if (wr && paddr == `RSC_OFF_CTRL) begin
				ctrl_ff <= pwdata;
			end
			// Trim word loaded from fuses; only programming mode may rewrite it
			if (!sync2_ff) begin
				cal_ff <= CAL_INIT & `RSC_CAL_MASK;
			end else if (wr && paddr == `RSC_OFF_FACTORY_CALIBRATION_WORD && prog_ff) begin
				cal_ff <= pwdata[13:0] & `RSC_CAL_MASK;
			end
		end
	end

	// Sticky event bits: set wins over the read clear
	// Taken from the new cause, since the stored one lags a one-cycle event
	assign ev = {1'b0, (nxt_cause == RSC_CAUSE_BOD), (nxt_cause == RSC_CAUSE_PIN_SLEEP),
		(nxt_cause == RSC_CAUSE_PIN_RUN), (nxt_cause == RSC_CAUSE_WDT_SLEEP),
		(nxt_cause == RSC_CAUSE_WDT_RUN), (nxt_cause == RSC_CAUSE_POR), 1'b0};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff <= 8'h00;
			mask_ff <= `RSC_IRQ_MASK_RESET;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			// Clear only bits already returned, so a setup-cycle event survives
			stat_ff <= (stat_ff & ~((rd && paddr == `RSC_OFF_IRQ_STAT) ? prdata_ff[7:0] : 8'h00))
				| ev;
			if (wr && paddr == `RSC_OFF_IRQ_MASK) begin
				mask_ff <= pwdata[7:0];
			end
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	// APB read mux, zero wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (clk_en && psel && !penable) begin
			case (paddr)
				`RSC_OFF_CAUSE: prdata_ff <= {25'h0000000, cause_ff, flags_ff};
				`RSC_OFF_CTRL: prdata_ff <= ctrl_ff;
				`RSC_OFF_FACTORY_CALIBRATION_WORD: prdata_ff <= cal_read(cal_ff);
				`RSC_OFF_SCRATCH: prdata_ff <= scratch_ff;
				`RSC_OFF_IRQ_STAT: prdata_ff <= {24'h000000, stat_ff};
				`RSC_OFF_IRQ_MASK: prdata_ff <= {24'h000000, mask_ff};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	// Open-drain pin is only ever released, so watchdog cannot pull it
	assign ext_pin_out = 1'b0;
	assign ext_pin_oe = 1'b0;
	assign ext_pin_pullup = pullup_ff;
	assign core_rst_n = sync2_ff;
	assign core_soft_rst_n = soft2_ff;
	assign prog_mode = prog_ff;
	assign irq = irq_ff;

	property p_wdt_no_pin;
		@(posedge pclk) disable iff (!presetn) wdt_hold_ff |-> !ext_pin_oe;
	endproperty
	a_wdt_no_pin: assert property (p_wdt_no_pin) else $error("pin driven");
	property p_por_hold;
		@(posedge pclk) disable iff (!presetn) (clk_en && por_hold_ff) |=> !sync1_ff;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("por not held");
	property p_bod_hold;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && supply.brownout_detect_en && supply.brownout_low) ##1 clk_en |=> !sync2_ff;
	endproperty
	a_bod_hold: assert property (p_bod_hold) else $error("bod not held");
	property p_cal_zero;
		@(posedge pclk) disable iff (!presetn) cal_ff[13] == 1'b0 && cal_ff[5] == 1'b0;
	endproperty
	a_cal_zero: assert property (p_cal_zero) else $error("cal bits set");
	property p_por_flags;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && nxt_cause == RSC_CAUSE_POR) |=> !flags_ff.por_n && flags_ff.expiry_n;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("por flags");
	property p_wake_no_reset;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && nxt_cause == RSC_CAUSE_WDT_SLEEP && !rst_req) |=> sync1_ff;
	endproperty
	a_wake_no_reset: assert property (p_wake_no_reset) else $error("wake reset");
	property p_tie;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && !ext_pin_enable) |=> ext_pin_pullup;
	endproperty
	a_tie: assert property (p_tie) else $error("no pullup");
	property p_release_sync;
		@(posedge pclk) disable iff (!presetn) $rose(sync2_ff) |-> $past(sync1_ff);
	endproperty
	a_release_sync: assert property (p_release_sync) else $error("bad release");
endmodule // rsc_reset_ctrl
`default_nettype wire

// ### tb/rsc_far_side.sv
// Purpose: far side model, external reset pin and supply monitors
// Assumes: bench sets the requested levels by non-blocking assignment after pclk rises
// Notes: pin has a board resistor to the supply, so a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side import rsc_pkg::*; (
	// Bench commands
	input wire logic press,
	input wire logic vdd_ok,
	input wire logic vdd_gnd,
	input wire logic bo_low,
	input wire logic bo_en,
	// Device pin controls
	input wire logic ext_pin_out,
	input wire logic ext_pin_oe,
	input wire logic ext_pin_pullup,
	// Levels seen by the device
	output logic ext_pin_in,
	output rsc_supply_s supply
);
	// Wire level: device drive wins, then the button, else resistor or weak pull-up
	assign ext_pin_in = ext_pin_oe ? ext_pin_out : (press ? 1'b0 : (1'b1 | ext_pin_pullup));
	// Supply monitor levels packed as the device expects them
	assign supply = '{supply_ok: vdd_ok, supply_at_gnd: vdd_gnd, brownout_low: bo_low,
		brownout_detect_en: bo_en};
endmodule // rsc_far_side
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for the reset source and calibration block
// Assumes: zero-wait APB slave, short filter and rearm counts
// Notes: one task per scenario; scenarios run in order on one device
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module tb_top import rsc_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, wdt_expire = 1'b0, wdt_asleep = 1'b0, sleep_enter = 1'b0;
	logic press = 1'b0, vdd_ok = 1'b0, vdd_gnd = 1'b0, bo_low = 1'b0, bo_en = 1'b0;
	logic ext_pin_enable = 1'b1, prog_entry = 1'b0, clk_en = 1'b1;
	logic ext_pin_in, ext_pin_out, ext_pin_oe, ext_pin_pullup;
	logic core_rst_n, core_soft_rst_n, prog_mode, irq;
	rsc_supply_s supply;
	int failures = 0, total_checks = 0, cycles = 0;
	logic [31:0] rd;

	// 8 ns clock
	always #4 pclk = ~pclk;

	rsc_far_side u_far (.press(press), .vdd_ok(vdd_ok), .vdd_gnd(vdd_gnd), .bo_low(bo_low),
		.bo_en(bo_en), .ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe),
		.ext_pin_pullup(ext_pin_pullup), .ext_pin_in(ext_pin_in), .supply(supply));
	// Short counts keep the run brief
	rsc_reset_ctrl #(.FILT_CYC(3), .REARM_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply(supply), .wdt_expire(wdt_expire), .wdt_asleep(wdt_asleep), .wdt_wake(1'b0),
		.sleep_enter(sleep_enter), .ext_pin_in(ext_pin_in), .ext_pin_out(ext_pin_out),
		.ext_pin_oe(ext_pin_oe), .ext_pin_pullup(ext_pin_pullup),
		.ext_pin_enable(ext_pin_enable), .prog_entry(prog_entry), .core_rst_n(core_rst_n),
		.core_soft_rst_n(core_soft_rst_n), .prog_mode(prog_mode), .irq(irq));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; holds everything until pready is seen high
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bounded wait for the combined reset to reach a level
	task automatic wait_rst(input logic v, input string what);
		int n;
		n = 0;
		while (core_rst_n !== v && n < 40) begin
			@(posedge pclk);
			n++;
		end
		check(what, core_rst_n, v);
	endtask

	task automatic hold_pin(input int n);
		@(posedge pclk);
		press <= 1'b1;
		repeat (n) @(posedge pclk);
		press <= 1'b0;
	endtask

	task automatic cause_is(input rsc_cause_e c, input string what);
		apb(1'b0, `RSC_OFF_CAUSE, 32'h0);
		check(what, rd[6:4], c);
	endtask

	task automatic t_power_on;
		repeat (10) @(posedge pclk);
		check("rst held low supply", core_rst_n, 1'b0);
		vdd_ok <= 1'b1;
		wait_rst(1'b1, "rst release");
		cause_is(RSC_CAUSE_POR, "cause por");
		check("por flags", rd[3:0], 4'h7);
		apb(1'b0, `RSC_OFF_FACTORY_CALIBRATION_WORD, 32'h0);
		check("factory_calibration_word init", rd, 32'h0000_0001);
		check("factory_calibration_word bit13", rd[13], 1'b0);
		apb(1'b1, `RSC_OFF_FACTORY_CALIBRATION_WORD, 32'h0000_3FFF);
		apb(1'b0, `RSC_OFF_FACTORY_CALIBRATION_WORD, 32'h0);
		check("factory_calibration_word write ignored", rd, 32'h0000_0001);
		apb(1'b0, 14'h0020, 32'h0);
		check("unmapped read", rd, 32'h0);
		$display("test power_on done");
	endtask

	task automatic t_irq;
		check("irq masked", irq, 1'b0);
		apb(1'b1, `RSC_OFF_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		check("irq unmasked", irq, 1'b1);
		apb(1'b0, `RSC_OFF_IRQ_STAT, 32'h0);
		check("stat por bit", rd[1], 1'b1);
		repeat (2) @(posedge pclk);
		check("irq cleared", irq, 1'b0);
		$display("test irq done");
	endtask

	task automatic t_pin;
		apb(1'b1, `RSC_OFF_SCRATCH, 32'hA5A5_5A5A);
		apb(1'b1, `RSC_OFF_CTRL, 32'h0);
		hold_pin(2);
		repeat (6) @(posedge pclk);
		check("glitch ignored", core_rst_n, 1'b1);
		hold_pin(8);
		wait_rst(1'b0, "pin reset");
		wait_rst(1'b1, "pin release");
		cause_is(RSC_CAUSE_PIN_RUN, "cause pin run");
		apb(1'b0, `RSC_OFF_SCRATCH, 32'h0);
		check("scratch kept", rd, 32'hA5A5_5A5A);
		apb(1'b0, `RSC_OFF_CTRL, 32'h0);
		check("ctrl reset value", rd, `RSC_CTRL_RESET);
		$display("test pin done");
	endtask

	task automatic t_sleep;
		@(posedge pclk);
		sleep_enter <= 1'b1;
		@(posedge pclk);
		sleep_enter <= 1'b0;
		hold_pin(8);
		wait_rst(1'b0, "pin sleep reset");
		wait_rst(1'b1, "pin sleep release");
		cause_is(RSC_CAUSE_PIN_SLEEP, "cause pin sleep");
		check("pin sleep flags", rd[1:0], 2'b10);
		@(posedge pclk);
		sleep_enter <= 1'b1;
		@(posedge pclk);
		sleep_enter <= 1'b0;
		wdt_asleep <= 1'b1;
		wdt_expire <= 1'b1;
		@(posedge pclk);
		wdt_expire <= 1'b0;
		repeat (8) @(posedge pclk);
		check("wake no reset", core_soft_rst_n, 1'b1);
		wdt_asleep <= 1'b0;
		apb(1'b0, `RSC_OFF_CAUSE, 32'h0);
		check("wake flags", rd[1:0], 2'b00);
		check("cause wake", rd[6:4], RSC_CAUSE_WDT_SLEEP);
		$display("test sleep done");
	endtask

	task automatic t_wdt_bod;
		@(posedge pclk);
		wdt_expire <= 1'b1;
		@(posedge pclk);
		wdt_expire <= 1'b0;
		wait_rst(1'b0, "wdt reset");
		check("pin not driven", ext_pin_oe, 1'b0);
		wait_rst(1'b1, "wdt release");
		cause_is(RSC_CAUSE_WDT_RUN, "cause wdt run");
		check("wdt expiry flag", rd[1], 1'b0);
		bo_en <= 1'b1;
		bo_low <= 1'b1;
		wait_rst(1'b0, "bod reset");
		repeat (10) @(posedge pclk);
		check("bod hold", core_rst_n, 1'b0);
		bo_low <= 1'b0;
		wait_rst(1'b1, "bod release");
		cause_is(RSC_CAUSE_BOD, "cause bod");
		apb(1'b0, `RSC_OFF_IRQ_STAT, 32'h0);
		check("stat causes", rd[7:0], 8'h7C);
		$display("test wdt_bod done");
	endtask

	task automatic t_supply;
		apb(1'b1, `RSC_OFF_CTRL, 32'h0);
		vdd_ok <= 1'b0;
		repeat (10) @(posedge pclk);
		check("no reset on decline", core_rst_n, 1'b1);
		vdd_gnd <= 1'b1;
		repeat (6) @(posedge pclk);
		vdd_gnd <= 1'b0;
		wait_rst(1'b0, "rearmed por");
		vdd_ok <= 1'b1;
		wait_rst(1'b1, "por release");
		apb(1'b0, `RSC_OFF_CTRL, 32'h0);
		check("ctrl on por", rd, `RSC_CTRL_RESET);
		ext_pin_enable <= 1'b0;
		prog_entry <= 1'b1;
		hold_pin(8);
		repeat (4) @(posedge pclk);
		check("pin tied", core_rst_n, 1'b1);
		check("pull-up on", ext_pin_pullup, 1'b1);
		check("prog entry", prog_mode, 1'b1);
		apb(1'b1, `RSC_OFF_FACTORY_CALIBRATION_WORD, 32'h0000_3FFF);
		apb(1'b0, `RSC_OFF_FACTORY_CALIBRATION_WORD, 32'h0);
		check("factory_calibration_word prog write", rd, 32'h0000_1FDF);
		// Frozen clock enable: a long press must not reach the reset
		clk_en <= 1'b0;
		ext_pin_enable <= 1'b1;
		hold_pin(8);
		repeat (2) @(posedge pclk);
		check("frozen", core_rst_n, 1'b1);
		clk_en <= 1'b1;
		$display("test supply done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles needed
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_power_on();
		t_irq();
		t_pin();
		t_sleep();
		t_wdt_bod();
		t_supply();
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
